// ### rtl/pattern_memory.sv
module pattern_memory
    import tdma_builder_pkg::*;
#(
    parameter int DEPTH  = 2500,
    parameter int ADDR_W = 12
) (
    input wire logic            core_clk,
    pattern_memory_if.store     mem
);
    pattern_word_t words [DEPTH];

    // Out-of-range indices are dropped rather than aliased
    always_ff @(posedge core_clk) begin
        if (mem.wr_en && (int'(mem.wr_addr) < DEPTH)) begin
            words[mem.wr_addr] <= mem.wr_data;
        end
    end

    // Flip-flop storage, so the read is immediate
    assign mem.rd_data = (int'(mem.rd_addr) < DEPTH) ? words[mem.rd_addr] : '0;
endmodule : pattern_memory

// ### rtl/pattern_memory_if.sv
interface pattern_memory_if
    import tdma_builder_pkg::*;
#(
    parameter int ADDR_W = 12
) ();
    logic                wr_en;
    logic [ADDR_W-1:0]   wr_addr;
    pattern_word_t       wr_data;
    logic [ADDR_W-1:0]   rd_addr;
    pattern_word_t       rd_data;

    modport builder (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store   (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : pattern_memory_if

// ### rtl/pn_sequence.sv
module pn_sequence #(
    parameter int               WIDTH    = 9,
    parameter logic [WIDTH-1:0] TAP_MASK = 9'h110
) (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic advance,
    output logic      pn_bit
);
    logic [WIDTH-1:0] lfsr_reg;

    // Seeded all ones; an all-zero state would lock up
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lfsr_reg <= '1;
        end else if (advance) begin
            lfsr_reg <= {lfsr_reg[WIDTH-2:0], ^(lfsr_reg & TAP_MASK)};
        end
    end

    assign pn_bit = lfsr_reg[WIDTH-1];
endmodule : pn_sequence

// ### rtl/tdma_builder_pkg.sv
package tdma_builder_pkg;

    // Builder and playback phases
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_BUILD = 3'h2,
        ST_PLAY  = 3'h4
    } build_state_e;

    // Where the sync marker fires
    typedef enum logic [1:0] {
        MARK_FRAME = 2'h0,
        MARK_SLOT  = 2'h1,
        MARK_ALL   = 2'h2
    } marker_sel_e;

    typedef logic [31:0] pattern_word_t;

endpackage : tdma_builder_pkg

// ### rtl/tdma_builder_regs.svh
`ifndef TDMA_BUILDER_REGS_SVH
`define TDMA_BUILDER_REGS_SVH

// Register byte offsets
`define OFS_SLOT_ENABLE   8'h00
`define OFS_SLOT_SOURCE   8'h04
`define OFS_MARKER        8'h08
`define OFS_USER_LENGTH   8'h0C
`define OFS_USER_INDEX    8'h10
`define OFS_USER_DATA     8'h14
`define OFS_STATUS        8'h18
`define OFS_IMAGE_WORDS   8'h1C
`define OFS_IMAGE_BLOCKS  8'h20
`define OFS_PLAY_ADDR     8'h24

// Reset values
`define RST_SLOT_ENABLE   8'h00
`define RST_SLOT_SOURCE   8'h00
`define RST_MARKER        5'h00
`define RST_USER_LENGTH   16'h0000

// Pattern word field positions
`define BIT_DATA          0
`define BIT_BURST         2
`define BIT_RESTART       7
`define BIT_SLOT_START    8
`define LSB_SLOT_NUM      9
`define MSB_SLOT_NUM      11

// Frame layout, in words (one word per bit period)
`define SLOTS_PER_FRAME   4'h8
`define SLOT_LAST_WORD    8'h9B
`define GUARD_SLOT_LAST   8'h9C
`define GUARD_SLOT_PHASE  2'h3
`define FIELD_ONE_START   8'h03
`define FIELD_TWO_START   8'h58
`define FIELD_BITS        16'h0039
`define TRAIN_START       8'h3D
`define TRAIN_END         8'h57
`define FRAME_WORDS       16'h04E2
`define FRAMES_PER_MULTI  5'h1A

// Memory allocation: 1024-byte blocks of 4-byte words
`define BLOCK_WORD_SHIFT  8
`define BLOCK_WORD_ROUND  16'h00FF

`endif

// ### rtl/tdma_framed_pattern_memory_builder.sv
// Notes on behaviour
// - Enabled-slot words get burst bit 1 and carry user or pseudo-random payload in data fields; a user field short of file gets 0.
// - Disabled-slot words get burst bit 0; their data bit is don't-care.
// - Restart bit is 1 only in the last word of the final frame; else 0.
// - After a restart word, the pattern begins again with the next frame.
// - Restart flag sits at bit 7 of the control byte.
// - Memory is static while playing; written once per configuration, read cyclically.
// - Rebuild only when data source or slot format changes, not on marker edits.
// - Slots are 156 words; every fourth slot has one extra guard word.
// - Normal burst: two 57-bit payload fields, other 42 bits builder generated.
// - User bits fill the slot frame after frame while a whole field remains.
// - Each bit position is one 32-bit word: data bit plus 31 control bits.
// - Sync marker marks frame start, one chosen slot start, or every slot start.
// - A slot has exactly one data source: pseudo-random or user file.
// - One user file may feed one slot or several slots.
// - Frames are laid out with eight slots.
// - Memory use reported in 1024-byte blocks, rounded up.
// - Generated image is kept apart from the retained user file copy.
// - Speech traffic channel multiframe counts 26 frames.
// - Bit 0 of each word is the payload data bit.
// - Bit 2 is the burst flag; payload is ignored when it is 0.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`include "tdma_builder_regs.svh"

module tdma_framed_pattern_memory_builder
    import tdma_builder_pkg::*;
#(
    parameter int          DEPTH      = 2500,
    parameter int          USER_BITS  = 456,
    parameter logic [25:0] TRAIN_SEQ  = 26'h0970897
) (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata,
    output logic             mod_data,
    output logic             burst_gate,
    output logic             pattern_restart,
    output logic             sync_marker,
    output logic             play_valid
);
    localparam int            AW       = $clog2(DEPTH);
    localparam int            UIW      = $clog2(USER_BITS);
    localparam logic [15:0]   USER_MAX = 16'(USER_BITS);
    localparam logic [AW:0]   FRAME_W  = (AW+1)'(`FRAME_WORDS);
    localparam logic [AW:0]   DEPTH_W  = (AW+1)'(DEPTH);

    build_state_e        state_reg;
    logic [7:0]          slot_enable_reg;
    logic [7:0]          slot_source_reg;
    logic [4:0]          marker_reg;
    logic [15:0]         user_len_reg;
    logic [15:0]         user_index_reg;
    logic [USER_BITS-1:0] user_bits_reg;
    logic [AW-1:0]       build_addr_reg;
    logic [2:0]          slot_reg;
    logic [7:0]          pos_reg;
    logic [15:0]         user_ptr_reg;
    logic                fill_reg;
    logic [AW:0]         image_words_reg;
    logic [AW-1:0]       play_addr_reg;
    pattern_word_t       played_word_reg;
    logic                sync_marker_reg;
    logic                play_valid_reg;
    logic [4:0]          frame_in_multi_reg;
    logic [31:0]         rdata_reg;

    logic                rebuild_req;
    logic                slot_on;
    logic                user_slot;
    logic                payload_pos;
    logic                field_start;
    logic                fill_now;
    logic                frame_end;
    logic                final_frame;
    logic [7:0]          slot_last;
    logic [15:0]         remain;
    logic                pn_bit;
    logic                pn_advance;
    logic [AW:0]         image_blocks;
    pattern_word_t       word_next;

    pattern_memory_if #(.ADDR_W(AW)) mem ();

    pattern_memory #(
        .DEPTH  (DEPTH),
        .ADDR_W (AW)
    ) u_memory (
        .core_clk (core_clk),
        .mem      (mem)
    );

    pn_sequence #(
        .WIDTH    (9),
        .TAP_MASK (9'h110)
    ) u_pn (
        .core_clk (core_clk),
        .srst     (srst),
        .advance  (pn_advance),
        .pn_bit   (pn_bit)
    );

    // Payload field positions within a slot, shared by builder and checks
    function automatic logic in_payload(input logic [7:0] pos);
        in_payload = ((pos >= `FIELD_ONE_START) && (pos < (`FIELD_ONE_START + 8'h39))) ||
                     ((pos >= `FIELD_TWO_START) && (pos < (`FIELD_TWO_START + 8'h39)));
    endfunction : in_payload

    // rebuild on source change
    // Marker edits never trigger this; a length write counts as a new file
    assign rebuild_req = reg_write && (
        ((reg_addr == `OFS_SLOT_ENABLE) && (reg_wdata[7:0] != slot_enable_reg)) ||
        ((reg_addr == `OFS_SLOT_SOURCE) && (reg_wdata[7:0] != slot_source_reg)) ||
        (reg_addr == `OFS_USER_LENGTH));

    // Configuration registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            slot_enable_reg <= `RST_SLOT_ENABLE;
            slot_source_reg <= `RST_SLOT_SOURCE;
            marker_reg      <= `RST_MARKER;
            user_len_reg    <= `RST_USER_LENGTH;
        end else if (reg_write) begin
            if (reg_addr == `OFS_SLOT_ENABLE) begin
                slot_enable_reg <= reg_wdata[7:0];
            end else if (reg_addr == `OFS_SLOT_SOURCE) begin
                slot_source_reg <= reg_wdata[7:0];
            end else if (reg_addr == `OFS_MARKER) begin
                marker_reg <= reg_wdata[4:0];
            end else if (reg_addr == `OFS_USER_LENGTH) begin
                // Clamped so the pointer never leaves the file buffer
                user_len_reg <= (reg_wdata[15:0] > USER_MAX) ? USER_MAX : reg_wdata[15:0];
            end
        end
    end

    // user file copy kept apart
    // Loading bits does not touch the image until the length is committed
    always_ff @(posedge core_clk) begin
        if (srst) begin
            user_index_reg <= 16'h0000;
            user_bits_reg  <= '0;
        end else if (reg_write && (reg_addr == `OFS_USER_INDEX)) begin
            user_index_reg <= reg_wdata[15:0];
        end else if (reg_write && (reg_addr == `OFS_USER_DATA)) begin
            if (user_index_reg < USER_MAX) begin
                user_bits_reg[user_index_reg[UIW-1:0]] <= reg_wdata[0];
            end
            user_index_reg <= user_index_reg + 16'h0001;
        end
    end

    assign slot_last   = (slot_reg[1:0] == `GUARD_SLOT_PHASE) ? `GUARD_SLOT_LAST
                                                              : `SLOT_LAST_WORD;
    assign frame_end   = (slot_reg == 3'(`SLOTS_PER_FRAME - 4'h1)) && (pos_reg == slot_last);
    assign slot_on     = slot_enable_reg[slot_reg];
    // any number of slots may take the file
    assign user_slot   = slot_on && slot_source_reg[slot_reg];
    assign payload_pos = in_payload(pos_reg);
    assign field_start = (pos_reg == `FIELD_ONE_START) || (pos_reg == `FIELD_TWO_START);
    assign remain      = user_len_reg - user_ptr_reg;
    assign fill_now    = user_slot && payload_pos &&
                         (field_start ? (remain >= `FIELD_BITS) : fill_reg);
    assign pn_advance  = (state_reg == ST_BUILD) && slot_on && !user_slot && payload_pos;

    // Last frame: less than a field of file left, no user slot, or the next frame would not fit
    assign final_frame = ((slot_enable_reg & slot_source_reg) == 8'h00) ||
                         (remain < `FIELD_BITS) ||
                         (({1'b0, build_addr_reg} + FRAME_W) >= DEPTH_W);

    // Word composition for the current build position
    always_comb begin
        word_next = '0;
        word_next[`BIT_SLOT_START]              = (pos_reg == 8'h00);
        word_next[`MSB_SLOT_NUM:`LSB_SLOT_NUM]  = slot_reg;
        if (slot_on) begin
            word_next[`BIT_BURST] = 1'b1;
            if (fill_now) begin
                word_next[`BIT_DATA] = user_bits_reg[user_ptr_reg[UIW-1:0]];
            end else if (payload_pos && !user_slot) begin
                word_next[`BIT_DATA] = pn_bit;
            end else if ((pos_reg >= `TRAIN_START) && (pos_reg < `TRAIN_END)) begin
                word_next[`BIT_DATA] = TRAIN_SEQ[5'(pos_reg - `TRAIN_START)];
            end
        end
        word_next[`BIT_RESTART] = frame_end && final_frame;
    end

    assign mem.wr_en   = (state_reg == ST_BUILD);
    assign mem.wr_addr = build_addr_reg;
    assign mem.wr_data = word_next;
    assign mem.rd_addr = play_addr_reg;

    // Phase control and build counters
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_reg       <= ST_IDLE;
            build_addr_reg  <= '0;
            slot_reg        <= 3'h0;
            pos_reg         <= 8'h00;
            user_ptr_reg    <= 16'h0000;
            fill_reg        <= 1'b0;
            image_words_reg <= '0;
        end else if (rebuild_req) begin
            // A rebuild stops playback; the old image is invalid
            state_reg       <= ST_BUILD;
            build_addr_reg  <= '0;
            slot_reg        <= 3'h0;
            pos_reg         <= 8'h00;
            user_ptr_reg    <= 16'h0000;
            fill_reg        <= 1'b0;
        end else if (state_reg == ST_BUILD) begin
            if (field_start && user_slot) begin
                fill_reg <= (remain >= `FIELD_BITS);
            end
            if (fill_now) begin
                user_ptr_reg <= user_ptr_reg + 16'h0001;
            end
            if (pos_reg == slot_last) begin
                pos_reg  <= 8'h00;
                slot_reg <= slot_reg + 3'h1;
            end else begin
                pos_reg <= pos_reg + 8'h01;
            end
            if (frame_end && final_frame) begin
                state_reg       <= ST_PLAY;
                image_words_reg <= {1'b0, build_addr_reg} + {{AW{1'b0}}, 1'b1};
            end else begin
                build_addr_reg <= build_addr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
        end
    end

    assign image_blocks = (image_words_reg + (AW+1)'(`BLOCK_WORD_ROUND)) >> `BLOCK_WORD_SHIFT;

    always_ff @(posedge core_clk) begin
        if (srst || (state_reg != ST_PLAY) || rebuild_req) begin
            play_addr_reg <= '0;
        end else if (mem.rd_data[`BIT_RESTART]) begin
            play_addr_reg <= '0;
        end else begin
            play_addr_reg <= play_addr_reg + {{(AW-1){1'b0}}, 1'b1};
        end
    end

    // Played word and sync marker, registered toward the modulator
    always_ff @(posedge core_clk) begin
        if (srst || (state_reg != ST_PLAY) || rebuild_req) begin
            played_word_reg <= '0;
            sync_marker_reg <= 1'b0;
            play_valid_reg  <= 1'b0;
        end else begin
            played_word_reg <= mem.rd_data;
            play_valid_reg  <= 1'b1;
            case (marker_reg[1:0])
                MARK_FRAME: sync_marker_reg <= mem.rd_data[`BIT_SLOT_START] &&
                    (mem.rd_data[`MSB_SLOT_NUM:`LSB_SLOT_NUM] == 3'h0);
                MARK_SLOT:  sync_marker_reg <= mem.rd_data[`BIT_SLOT_START] &&
                    (mem.rd_data[`MSB_SLOT_NUM:`LSB_SLOT_NUM] == marker_reg[4:2]);
                MARK_ALL:   sync_marker_reg <= mem.rd_data[`BIT_SLOT_START];
                default:    sync_marker_reg <= 1'b0;
            endcase
        end
    end

    // 26-frame multiframe counter
    // Starts one short so the first frame played reads as frame 0
    always_ff @(posedge core_clk) begin
        if (srst || (state_reg != ST_PLAY)) begin
            frame_in_multi_reg <= `FRAMES_PER_MULTI - 5'h01;
        end else if (mem.rd_data[`BIT_SLOT_START] &&
                     (mem.rd_data[`MSB_SLOT_NUM:`LSB_SLOT_NUM] == 3'h0)) begin
            frame_in_multi_reg <= (frame_in_multi_reg == (`FRAMES_PER_MULTI - 5'h01)) ? 5'h00
                                  : frame_in_multi_reg + 5'h01;
        end
    end

    // Read port; data stands one cycle only, unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (srst || !reg_read) begin
            rdata_reg <= 32'h0000_0000;
        end else if (reg_addr == `OFS_SLOT_ENABLE) begin
            rdata_reg <= {24'h000000, slot_enable_reg};
        end else if (reg_addr == `OFS_SLOT_SOURCE) begin
            rdata_reg <= {24'h000000, slot_source_reg};
        end else if (reg_addr == `OFS_MARKER) begin
            rdata_reg <= {27'h0000000, marker_reg};
        end else if (reg_addr == `OFS_USER_LENGTH) begin
            rdata_reg <= {16'h0000, user_len_reg};
        end else if (reg_addr == `OFS_USER_INDEX) begin
            rdata_reg <= {16'h0000, user_index_reg};
        end else if (reg_addr == `OFS_STATUS) begin
            rdata_reg <= {19'h00000, frame_in_multi_reg, 5'h00, state_reg};
        end else if (reg_addr == `OFS_IMAGE_WORDS) begin
            rdata_reg <= 32'(image_words_reg);
        end else if (reg_addr == `OFS_IMAGE_BLOCKS) begin
            rdata_reg <= 32'(image_blocks);
        end else if (reg_addr == `OFS_PLAY_ADDR) begin
            rdata_reg <= 32'(play_addr_reg);
        end else begin
            rdata_reg <= 32'h0000_0000;
        end
    end

    assign reg_rdata       = rdata_reg;
    assign mod_data        = played_word_reg[`BIT_DATA] & played_word_reg[`BIT_BURST];
    assign burst_gate      = played_word_reg[`BIT_BURST];
    assign pattern_restart = played_word_reg[`BIT_RESTART];
    assign sync_marker     = sync_marker_reg;
    assign play_valid      = play_valid_reg;

    a_burst_enabled: assert property (@(posedge core_clk) disable iff (srst)
        (mem.wr_en && slot_enable_reg[mem.wr_data[`MSB_SLOT_NUM:`LSB_SLOT_NUM]])
        |-> mem.wr_data[`BIT_BURST])
        else $error("enabled slot word written without burst");

    a_burst_disabled: assert property (@(posedge core_clk) disable iff (srst)
        (mem.wr_en && !slot_enable_reg[mem.wr_data[`MSB_SLOT_NUM:`LSB_SLOT_NUM]])
        |-> !mem.wr_data[`BIT_BURST])
        else $error("disabled slot word written with burst");

    a_restart_then_play: assert property (@(posedge core_clk) disable iff (srst)
        (mem.wr_en && mem.wr_data[`BIT_RESTART] && !rebuild_req) |=> (state_reg == ST_PLAY))
        else $error("restart written before the final word");

    a_wrap_after_restart: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY && !rebuild_req && mem.rd_data[`BIT_RESTART])
        |=> (play_addr_reg == '0) ##1 (play_addr_reg == {{(AW-1){1'b0}}, 1'b1}) or
            (play_addr_reg == '0) ##1 (state_reg != ST_PLAY))
        else $error("playback did not wrap after restart");

    a_static_memory: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY) |-> !mem.wr_en)
        else $error("pattern memory written during playback");

    a_marker_no_rebuild: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY && reg_write && reg_addr == `OFS_MARKER)
        |=> (state_reg == ST_PLAY))
        else $error("marker change disturbed playback");

    a_slot_length: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_BUILD && $past(state_reg) == ST_BUILD && pos_reg == 8'h00 &&
         slot_reg != 3'h0 && !$past(rebuild_req))
        |-> ($past(pos_reg) == ((slot_reg[1:0] == 2'h0) ? `GUARD_SLOT_LAST : `SLOT_LAST_WORD)))
        else $error("slot length wrong");

    a_user_in_field: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_BUILD && !rebuild_req && user_ptr_reg != $past(user_ptr_reg) &&
         $past(state_reg) == ST_BUILD && !$past(rebuild_req)) |-> $past(in_payload(pos_reg)))
        else $error("user bit consumed outside a payload field");

    a_play_advance: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY && !rebuild_req && !mem.rd_data[`BIT_RESTART])
        |=> (state_reg != ST_PLAY) || (play_addr_reg == $past(play_addr_reg) + 1'b1))
        else $error("playback address did not advance by one");

    a_gate_follows: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY && !rebuild_req) |=> (burst_gate == $past(mem.rd_data[`BIT_BURST])))
        else $error("burst gate does not follow played word");

    a_marker_all: assert property (@(posedge core_clk) disable iff (srst)
        (state_reg == ST_PLAY && !rebuild_req && marker_reg[1:0] == 2'h2)
        |=> (sync_marker == $past(mem.rd_data[`BIT_SLOT_START])))
        else $error("all-slot marker misplaced");

    a_multiframe_range: assert property (@(posedge core_clk) disable iff (srst)
        frame_in_multi_reg < `FRAMES_PER_MULTI)
        else $error("multiframe counter beyond 26 frames");
endmodule : tdma_framed_pattern_memory_builder

// ### tb/mod_sink.sv
module mod_sink (
    input  wire logic core_clk,
    input  wire logic srst,
    input  wire logic play_valid,
    input  wire logic mod_data,
    input  wire logic burst_gate,
    input  wire logic pattern_restart,
    input  wire logic sync_marker,
    output int        tally[5]
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt[4];
    // Tally one pass of played words; the restart word closes it
    always @(posedge core_clk) begin
        if (srst || play_valid !== 1'h1) begin
            for (int k = 0; k < 4; k++)
                cnt[k] = 0;
        end else begin
            cnt[0]++;
            cnt[1] += int'(burst_gate === 1'h1);
            cnt[2] += int'(mod_data === 1'h1);
            cnt[3] += int'(sync_marker === 1'h1);
            if (pattern_restart === 1'h1) begin
                // Element copy keeps free simulators happy
                for (int k = 0; k < 4; k++) begin
                    tally[k] = cnt[k];
                    cnt[k] = 0;
                end
                tally[4]++;
            end
        end
    end
endmodule : mod_sink

// ### tb/tdma_framed_pattern_memory_builder_test.sv
`include "tdma_builder_regs.svh"
module tdma_framed_pattern_memory_builder_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk  = 1'h0;
    logic        srst      = 1'h1;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic        reg_write = 1'h0;
    logic        reg_read  = 1'h0;
    logic [31:0] reg_rdata;
    logic        mod_data, burst_gate, restart, sync_marker, play_valid;
    int          tally[5];
    int          bad_count  = 0;
    int          n_compared = 0;
    always #5 core_clk = ~core_clk;
    // Training bits zeroed so the ones count is payload only
    tdma_framed_pattern_memory_builder #(.TRAIN_SEQ(26'h0000000)) dut (
        .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mod_data(mod_data), .burst_gate(burst_gate), .pattern_restart(restart),
        .sync_marker(sync_marker), .play_valid(play_valid));
    mod_sink sink (.core_clk(core_clk), .srst(srst), .play_valid(play_valid),
        .mod_data(mod_data), .burst_gate(burst_gate), .pattern_restart(restart),
        .sync_marker(sync_marker), .tally(tally));
    task automatic tally_and_finish;
        if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t register read %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_tally(input int idx, input int exp);
        n_compared++;
        if (tally[idx] != exp) begin
            bad_count++;
            $display("[ERR] %0t playback count %0d is %0d, expected %0d", $time, idx,
                     tally[idx], exp);
        end
    endtask : chk_tally
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge core_clk);
        reg_write <= 1'h0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge core_clk);
        reg_read <= 1'h0;
        #1 chk(reg_rdata & m, exp);
    endtask : rd
    // Two restarts, so the tallies hold one whole pass after any change
    task automatic play(input int len, input int bursts, input int ones, input int marks);
        int start;
        start = tally[4];
        for (int i = 0; i < 9000 && tally[4] < start + 2; i++)
            @(posedge core_clk);
        chk_tally(4, start + 2);
        chk_tally(0, len);
        chk_tally(1, bursts);
        chk_tally(2, ones);
        chk_tally(3, marks);
    endtask : play
    initial begin
        repeat (3) @(posedge core_clk);
        srst <= 1'h0;
        // Idle after reset; an unmapped place reads zero
        rd(`OFS_STATUS, 32'h00000007, 32'h00000001);
        rd(8'h40, 32'hFFFFFFFF, 32'h00000000);
        // Slot one from a 228-bit file, every third bit set
        wr(`OFS_SLOT_ENABLE, 32'h00000002);
        wr(`OFS_SLOT_SOURCE, 32'h00000002);
        wr(`OFS_USER_INDEX, 32'h00000000);
        for (int i = 0; i < 228; i++)
            wr(`OFS_USER_DATA, {31'h00000000, i % 3 == 0});
        wr(`OFS_USER_LENGTH, 32'h000000E4);
        rd(`OFS_USER_INDEX, 32'h0000FFFF, 32'h000000E4);
        play(2 * 1250, 2 * 156, (228 + 2) / 3, 2);
        rd(`OFS_IMAGE_WORDS, 32'hFFFFFFFF, 32'h000009C4);
        rd(`OFS_IMAGE_BLOCKS, 32'hFFFFFFFF, 32'h0000000A);
        // Marker edits must leave playback running
        wr(`OFS_MARKER, 32'h00000002);
        rd(`OFS_STATUS, 32'h00000007, 32'h00000004);
        play(2 * 1250, 2 * 156, (228 + 2) / 3, 16);
        wr(`OFS_MARKER, 32'h00000005);
        play(2 * 1250, 2 * 156, (228 + 2) / 3, 2);
        // 100 bits: second field too short, so one frame only
        wr(`OFS_USER_LENGTH, 32'h00000064);
        play(1250, 156, (57 + 2) / 3, 1);
        rd(`OFS_IMAGE_BLOCKS, 32'hFFFFFFFF, 32'h00000005);
        // Two user slots share one pointer; marker selection 3 never fires
        wr(`OFS_SLOT_ENABLE, 32'h00000022);
        wr(`OFS_SLOT_SOURCE, 32'h00000022);
        wr(`OFS_MARKER, 32'h00000003);
        play(1250, 2 * 156, (57 + 2) / 3, 0);
        rd(`OFS_SLOT_SOURCE, 32'hFFFFFFFF, 32'h00000022);
        // Oversized length is clamped to the file buffer and starts a build
        wr(`OFS_USER_LENGTH, 32'h0000FFFF);
        rd(`OFS_USER_LENGTH, 32'hFFFFFFFF, 32'h000001C8);
        rd(`OFS_STATUS, 32'h00000007, 32'h00000002);
        tally_and_finish();
    end
    // Run needs about 25500 cycles; a hang is cut at 40000
    initial begin
        #400000;
        bad_count++;
        $display("[ERR] %0t run did not finish", $time);
        tally_and_finish();
    end
endmodule : tdma_framed_pattern_memory_builder_test
